// [ddio_regs.svh]
// Object indices, sub-indices, field positions and reset values of the digital I/O objects.
`ifndef DDIO_REGS_SVH
`define DDIO_REGS_SVH

// ****************************************************************
// Object indices and sub-indices
// ****************************************************************
`define DDIO_IDX_INPUT_STATUS 16'h60FD
`define DDIO_IDX_OUTPUTS      16'h60FE
`define DDIO_SUB_VAR          8'h00
`define DDIO_SUB_COUNT        8'h00
`define DDIO_SUB_LEVEL        8'h01
`define DDIO_SUB_MASK         8'h02

// ****************************************************************
// Reset values
// ****************************************************************
`define DDIO_RST_INPUT_STATUS 32'h00000000
`define DDIO_RST_COUNT        32'h00000002
`define DDIO_RST_LEVEL        32'h00000000
`define DDIO_RST_MASK         32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define DDIO_IN_NEG_LIMIT_BIT 0
`define DDIO_IN_POS_LIMIT_BIT 1
`define DDIO_IN_HOME_BIT      2
`define DDIO_IN_INTERLOCK_BIT 3
`define DDIO_RSVD_LSB         4
`define DDIO_RSVD_MSB         15
`define DDIO_GP_LSB           16
`define DDIO_GP_MSB           31
`define DDIO_GP_FIELD_MASK    32'hFFFF0000

`endif

// [ddio_pkg.sv]
// Types shared by the digital I/O object block.
package ddio_pkg;

  typedef logic [31:0] ddio_word_t;
  typedef logic [15:0] ddio_gp_t;
  typedef logic [15:0] ddio_index_t;
  typedef logic [7:0]  ddio_subidx_t;

  typedef enum logic [2:0]
  {
    DDIO_OBJ_NONE,
    DDIO_OBJ_INPUTS,
    DDIO_OBJ_COUNT,
    DDIO_OBJ_LEVEL,
    DDIO_OBJ_MASK
  } ddio_obj_e;

endpackage

// [ddio_out_if.sv]
// Carrier between the object decoder and the output stage.
`timescale 1ns/10ps
interface ddio_out_if;
  import ddio_pkg::*;

  logic     apply;
  ddio_gp_t value;
  ddio_gp_t mask;
  ddio_gp_t levels;

  modport ctrl
  (
    output apply,
    output value,
    output mask,
    input  levels
  );

  modport stage
  (
    input  apply,
    input  value,
    input  mask,
    output levels
  );
endinterface

// [ddio_out_stage.sv]
// Output latch that takes requested levels only where the mask selects them.
`timescale 1ns/10ps
module ddio_out_stage
#(
  parameter logic [15:0] AVAIL_MASK = 16'hFFFF
)
(
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  ddio_out_if.stage out_if
);
  import ddio_pkg::*;

  ddio_gp_t levels_q;
  ddio_gp_t levels_d;

  // ****************************************************************
  // Masked update
  // ****************************************************************
  always_comb
  begin
    levels_d = levels_q;
    if (out_if.apply)
    begin
      levels_d = (levels_q & ~(out_if.mask & AVAIL_MASK))
               | (out_if.value & out_if.mask & AVAIL_MASK); // [R5] [R6]
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      levels_q <= 16'h0000;
    end
    else
    begin
      levels_q <= levels_d;
    end
  end

  assign out_if.levels = levels_q;
endmodule

// [ddio_top.sv]
// Digital input status word and masked digital output object of the drive.
// ****************************************************************
// Notes on behaviour
// [R1] An input status bit reads one while its input is high and zero while it is low.
// [R2] General inputs zero to fifteen appear in status bits 16 to 31 in ascending order.
// [R3] Negative limit, positive limit, home and interlock sit in status bits 0 to 3, 4 to 15 reserved.
// [R4] A profile input is also a general input, so a change moves both of its status bits.
// [R5] An output goes high when its level request bit is one and low when it is zero.
// [R6] Only outputs selected by the write mask take the level request; others hold.
// [R7] Bits 16 to 31 of level request and mask steer general outputs zero to fifteen.
// [R8] Writing the mask switches every selected output to its held level request; the code switches only outputs set in AVAIL_OUT, others stay low.
// [R9] Mask and level may be written in either order; a later level write applies to masked outputs.
// [R10] A write that selects an output the product lacks raises an emergency pulse.
// [R11] Reserved status bits read zero and reserved level and mask bits ignore writes.
// ****************************************************************
`timescale 1ns/10ps
`include "ddio_regs.svh"
module ddio_top
#(
  parameter int          NEG_LIMIT_IN = 0,
  parameter int          POS_LIMIT_IN = 1,
  parameter int          HOME_IN      = 2,
  parameter int          INTERLOCK_IN = 3,
  parameter logic [15:0] AVAIL_OUT    = 16'hFFFF
)
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_srst,
  input  wire ddio_pkg::ddio_gp_t    i_gp_in,
  input  wire logic                  i_obj_valid,
  input  wire logic                  i_obj_write,
  input  wire ddio_pkg::ddio_index_t i_obj_index,
  input  wire ddio_pkg::ddio_subidx_t i_obj_subidx,
  input  wire ddio_pkg::ddio_word_t  i_obj_wdata,
  output logic                       o_obj_ready,
  output logic                       o_obj_done,
  output logic                       o_obj_abort,
  output ddio_pkg::ddio_word_t       o_obj_rdata,
  output ddio_pkg::ddio_gp_t         o_gp_out,
  output logic                       o_emcy_pulse,
  output ddio_pkg::ddio_gp_t         o_emcy_outputs
);
  import ddio_pkg::*;

  ddio_out_if out_bus ();

  ddio_word_t status_q;
  ddio_word_t status_d;
  ddio_word_t level_q;
  ddio_word_t level_d;
  ddio_word_t mask_q;
  ddio_word_t mask_d;
  logic       done_q;
  logic       done_d;
  logic       abort_q;
  logic       abort_d;
  ddio_word_t rdata_q;
  ddio_word_t rdata_d;
  logic       emcy_q;
  logic       emcy_d;
  ddio_gp_t   emcy_bits_q;
  ddio_gp_t   emcy_bits_d;
  ddio_obj_e  obj_sel;
  ddio_gp_t   bad_bits;

  // ****************************************************************
  // Object decode
  // ****************************************************************
  function automatic ddio_obj_e obj_decode(input ddio_index_t idx, input ddio_subidx_t sub);
    ddio_obj_e sel;
    sel = DDIO_OBJ_NONE;
    if (idx == `DDIO_IDX_INPUT_STATUS && sub == `DDIO_SUB_VAR)
    begin
      sel = DDIO_OBJ_INPUTS;
    end
    else if (idx == `DDIO_IDX_OUTPUTS)
    begin
      unique case (sub)
        `DDIO_SUB_COUNT: sel = DDIO_OBJ_COUNT;
        `DDIO_SUB_LEVEL: sel = DDIO_OBJ_LEVEL;
        `DDIO_SUB_MASK:  sel = DDIO_OBJ_MASK;
        default:         sel = DDIO_OBJ_NONE;
      endcase
    end
    return sel;
  endfunction

  assign obj_sel     = obj_decode(i_obj_index, i_obj_subidx);
  assign o_obj_ready = 1'b1;

  // ****************************************************************
  // Input status word
  // ****************************************************************
  always_comb
  begin
    status_d = `DDIO_RST_INPUT_STATUS; // [R11]
    status_d[`DDIO_GP_MSB:`DDIO_GP_LSB] = i_gp_in; // [R1] [R2]
    status_d[`DDIO_IN_NEG_LIMIT_BIT] = i_gp_in[NEG_LIMIT_IN]; // [R3] [R4]
    status_d[`DDIO_IN_POS_LIMIT_BIT] = i_gp_in[POS_LIMIT_IN]; // [R3] [R4]
    status_d[`DDIO_IN_HOME_BIT]      = i_gp_in[HOME_IN]; // [R3] [R4]
    status_d[`DDIO_IN_INTERLOCK_BIT] = i_gp_in[INTERLOCK_IN]; // [R3] [R4]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      status_q <= `DDIO_RST_INPUT_STATUS;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // ****************************************************************
  // Output entries and access answers
  // ****************************************************************
  assign bad_bits = i_obj_wdata[`DDIO_GP_MSB:`DDIO_GP_LSB] & ~AVAIL_OUT;

  always_comb
  begin
    level_d     = level_q;
    mask_d      = mask_q;
    done_d      = 1'b0;
    abort_d     = 1'b0;
    rdata_d     = 32'h00000000;
    emcy_d      = 1'b0;
    emcy_bits_d = emcy_bits_q;
    if (i_obj_valid)
    begin
      done_d = 1'b1;
      unique case (obj_sel)
        DDIO_OBJ_INPUTS:
        begin
          rdata_d = status_q;
          abort_d = i_obj_write;
        end
        DDIO_OBJ_COUNT:
        begin
          rdata_d = `DDIO_RST_COUNT;
          abort_d = i_obj_write;
        end
        DDIO_OBJ_LEVEL:
        begin
          rdata_d = level_q;
          if (i_obj_write)
          begin
            level_d = i_obj_wdata & `DDIO_GP_FIELD_MASK; // [R7] [R11]
          end
        end
        DDIO_OBJ_MASK:
        begin
          rdata_d = mask_q;
          if (i_obj_write)
          begin
            mask_d = i_obj_wdata & `DDIO_GP_FIELD_MASK; // [R7] [R11]
          end
        end
        DDIO_OBJ_NONE:
        begin
          abort_d = 1'b1;
        end
      endcase
      if (i_obj_write && (obj_sel == DDIO_OBJ_LEVEL || obj_sel == DDIO_OBJ_MASK)
          && bad_bits != 16'h0000)
      begin
        emcy_d      = 1'b1; // [R10]
        emcy_bits_d = bad_bits;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      level_q     <= `DDIO_RST_LEVEL;
      mask_q      <= `DDIO_RST_MASK;
      done_q      <= 1'b0;
      abort_q     <= 1'b0;
      rdata_q     <= 32'h00000000;
      emcy_q      <= 1'b0;
      emcy_bits_q <= 16'h0000;
    end
    else
    begin
      level_q     <= level_d;
      mask_q      <= mask_d;
      done_q      <= done_d;
      abort_q     <= abort_d;
      rdata_q     <= rdata_d;
      emcy_q      <= emcy_d;
      emcy_bits_q <= emcy_bits_d;
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  assign out_bus.apply = i_obj_valid && i_obj_write
                         && (obj_sel == DDIO_OBJ_LEVEL || obj_sel == DDIO_OBJ_MASK); // [R8] [R9]
  assign out_bus.value = level_d[`DDIO_GP_MSB:`DDIO_GP_LSB]; // [R7]
  assign out_bus.mask  = mask_d[`DDIO_GP_MSB:`DDIO_GP_LSB]; // [R7]

  ddio_out_stage
  #(
    .AVAIL_MASK (AVAIL_OUT)
  )
  u_out_stage
  (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .out_if     (out_bus.stage)
  );

  assign o_gp_out       = out_bus.levels;
  assign o_obj_done     = done_q;
  assign o_obj_abort    = abort_q;
  assign o_obj_rdata    = rdata_q;
  assign o_emcy_pulse   = emcy_q;
  assign o_emcy_outputs = emcy_bits_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  logic mask_wr;
  logic level_wr;
  assign mask_wr  = i_obj_valid && i_obj_write && obj_sel == DDIO_OBJ_MASK;
  assign level_wr = i_obj_valid && i_obj_write && obj_sel == DDIO_OBJ_LEVEL;

  property p_gp_status;
    !$past(i_srst) |-> status_q[31:16] == $past(i_gp_in);
  endproperty
  a_gp_status: assert property (p_gp_status) else $error("General input status wrong"); // [R1] [R2]

  property p_profile_status;
    !$past(i_srst) |-> status_q[3:0] == {$past(i_gp_in[INTERLOCK_IN]), $past(i_gp_in[HOME_IN]),
                          $past(i_gp_in[POS_LIMIT_IN]), $past(i_gp_in[NEG_LIMIT_IN])};
  endproperty
  a_profile_status: assert property (p_profile_status) else $error("Profile status wrong"); // [R3]

  property p_both_change;
    $changed(i_gp_in[NEG_LIMIT_IN]) |=> $changed(status_q[0])
                                        && $changed(status_q[16 + NEG_LIMIT_IN]);
  endproperty
  a_both_change: assert property (p_both_change) else $error("Limit bits did not move together"); // [R4]

  property p_reserved_zero;
    status_q[15:4] == 12'h000 && level_q[15:0] == 16'h0000 && mask_q[15:0] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero"); // [R11]

  property p_mask_write_applies;
    mask_wr |=> ((o_gp_out ^ level_q[31:16]) & mask_q[31:16] & AVAIL_OUT) == 16'h0000;
  endproperty
  a_mask_write_applies: assert property (p_mask_write_applies) else $error("Mask write missed"); // [R8] [R5]

  property p_level_second;
    level_wr ##1 1'b1 |-> ((o_gp_out ^ level_q[31:16]) & mask_q[31:16] & AVAIL_OUT) == 16'h0000;
  endproperty
  a_level_second: assert property (p_level_second) else $error("Level write not applied"); // [R9] [R7]

  property p_unmasked_hold;
    (mask_wr || level_wr) |=> ((o_gp_out ^ $past(o_gp_out)) & ~(mask_q[31:16] & AVAIL_OUT))
                               == 16'h0000;
  endproperty
  a_unmasked_hold: assert property (p_unmasked_hold) else $error("Unmasked output changed"); // [R6]

  property p_quiet_hold;
    !(mask_wr || level_wr) |=> $stable(o_gp_out);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("Output moved without write"); // [R6]

  property p_emcy;
    (mask_wr || level_wr) |=> o_emcy_pulse == ($past(bad_bits) != 16'h0000);
  endproperty
  a_emcy: assert property (p_emcy) else $error("Emergency pulse wrong"); // [R10]

  property p_emcy_cause;
    !(mask_wr || level_wr) |=> !o_emcy_pulse;
  endproperty
  a_emcy_cause: assert property (p_emcy_cause) else $error("Emergency without write"); // [R10]

  property p_emcy_bits;
    o_emcy_pulse |-> o_emcy_outputs != 16'h0000 && (o_emcy_outputs & AVAIL_OUT) == 16'h0000;
  endproperty
  a_emcy_bits: assert property (p_emcy_bits) else $error("Emergency bits wrong"); // [R10]

  property p_absent_low;
    (o_gp_out & ~AVAIL_OUT) == 16'h0000;
  endproperty
  a_absent_low: assert property (p_absent_low) else $error("Absent output driven"); // [R10]

  property p_read_status;
    i_obj_valid && !i_obj_write && obj_sel == DDIO_OBJ_INPUTS |=> o_obj_rdata == $past(status_q);
  endproperty
  a_read_status: assert property (p_read_status) else $error("Status read wrong"); // [R11]

  c_mask_then_level: cover property (mask_wr ##[1:20] level_wr);
  c_level_then_mask: cover property (level_wr ##[1:20] mask_wr);
  c_emcy: cover property (o_emcy_pulse);
  c_limit_toggle: cover property ($rose(status_q[0]));
endmodule

// [ddio_master_model.sv]
// Fieldbus master model that reads and writes the drive objects.
`timescale 1ns/10ps
module ddio_master_model
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_done,
  input  wire logic                   i_abort,
  input  wire ddio_pkg::ddio_word_t   i_rdata,
  output logic                        o_valid,
  output logic                        o_write,
  output ddio_pkg::ddio_index_t       o_index,
  output ddio_pkg::ddio_subidx_t      o_subidx,
  output ddio_pkg::ddio_word_t        o_wdata
);
  import ddio_pkg::*;

  initial
  begin
    o_valid = 1'h0;
    o_write = 1'h0;
    o_index = 16'h0000;
    o_subidx = 8'h00;
    o_wdata = 32'h00000000;
  end

  // One access in any object order the caller picks.
  task automatic access(input logic wr, input ddio_index_t ix, input ddio_subidx_t sx,
                        input ddio_word_t wd, output logic dn, output logic ab,
                        output ddio_word_t rd);
    @(posedge i_core_clk);
    o_valid <= 1'h1;
    o_write <= wr;
    o_index <= ix;
    o_subidx <= sx;
    o_wdata <= wd;
    @(posedge i_core_clk);
    o_valid <= 1'h0;
    o_write <= ~wr;
    o_index <= ~ix;
    o_subidx <= ~sx;
    o_wdata <= ~wd;
    #1;
    dn = i_done;
    ab = i_abort;
    rd = i_rdata;
  endtask
endmodule

// [tb.sv]
// Self-checking bench of the digital I/O object block.
`timescale 1ns/10ps
`include "ddio_regs.svh"
module tb;
  import ddio_pkg::*;
  localparam logic [15:0] AVAIL = 16'h00FF;
  logic       clk;
  logic       srst;
  ddio_gp_t   gp_in;
  logic       valid;
  logic       wr;
  ddio_index_t  idx;
  ddio_subidx_t sub;
  ddio_word_t wdata;
  logic       done;
  logic       ready;
  logic       abort;
  ddio_word_t rdata;
  ddio_gp_t   gp_out;
  logic       emcy;
  ddio_gp_t   emcy_outs;
  logic       dn;
  logic       ab;
  ddio_word_t rd;
  ddio_gp_t   lvl;
  ddio_gp_t   msk;
  ddio_gp_t   exp_out;
  int         fail_count;
  int         total_checks;

  ddio_top #(.AVAIL_OUT(AVAIL)) u_ddio_top
  (
    .i_core_clk(clk), .i_srst(srst), .i_gp_in(gp_in), .i_obj_valid(valid),
    .i_obj_write(wr), .i_obj_index(idx), .i_obj_subidx(sub), .i_obj_wdata(wdata),
    .o_obj_ready(ready), .o_obj_done(done), .o_obj_abort(abort), .o_obj_rdata(rdata),
    .o_gp_out(gp_out), .o_emcy_pulse(emcy), .o_emcy_outputs(emcy_outs)
  );

  ddio_master_model u_ddio_master_model
  (
    .i_core_clk(clk), .i_done(done), .i_abort(abort), .i_rdata(rdata), .o_valid(valid),
    .o_write(wr), .o_index(idx), .o_subidx(sub), .o_wdata(wdata)
  );

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  function automatic ddio_word_t exp_status(input ddio_gp_t g);
    return {g, 12'h000, g[3], g[2], g[1], g[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_exp(input ddio_index_t ix, input ddio_subidx_t sx,
                        input ddio_word_t ev, input logic eab);
    u_ddio_master_model.access(1'h0, ix, sx, 32'h00000000, dn, ab, rd);
    chk("ready", {31'h0, ready}, 32'h1);
    chk("done", {31'h0, dn}, 32'h1);
    chk("abort", {31'h0, ab}, {31'h0, eab});
    chk("rdata", rd, ev);
  endtask

  task automatic wr_out(input ddio_subidx_t sx, input ddio_word_t wd);
    ddio_gp_t m;
    u_ddio_master_model.access(1'h1, `DDIO_IDX_OUTPUTS, sx, wd, dn, ab, rd);
    chk("wr_rdata", rd, {(sx == `DDIO_SUB_LEVEL) ? lvl : msk, 16'h0000});
    if (sx == `DDIO_SUB_LEVEL) lvl = wd[31:16];
    else msk = wd[31:16];
    m = msk & AVAIL;
    exp_out = (exp_out & ~m) | (lvl & m);
    chk("done", {31'h0, dn}, 32'h1);
    chk("abort", {31'h0, ab}, 32'h0);
    chk("emcy", {31'h0, emcy}, {31'h0, |(wd[31:16] & ~AVAIL)});
    if (emcy === 1'h1) chk("emcy_outs", {16'h0, emcy_outs}, {16'h0, wd[31:16] & ~AVAIL});
    chk("gp_out", {16'h0, gp_out}, {16'h0, exp_out});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial
  begin
    ddio_gp_t v;
    srst = 1'h1;
    gp_in = 16'h0000;
    lvl = 16'h0000;
    msk = 16'h0000;
    exp_out = 16'h0000;
    fail_count = 0;
    total_checks = 0;
    void'($urandom(85));
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    rd_exp(`DDIO_IDX_INPUT_STATUS, `DDIO_SUB_VAR, `DDIO_RST_INPUT_STATUS, 1'h0);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_COUNT, `DDIO_RST_COUNT, 1'h0);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_LEVEL, `DDIO_RST_LEVEL, 1'h0);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_MASK, `DDIO_RST_MASK, 1'h0);
    rd_exp(16'h1234, 8'h00, 32'h00000000, 1'h1);
    rd_exp(`DDIO_IDX_OUTPUTS, 8'h03, 32'h00000000, 1'h1);
    u_ddio_master_model.access(1'h1, `DDIO_IDX_OUTPUTS, `DDIO_SUB_COUNT, 32'h00050000, dn, ab, rd);
    chk("ro_abort", {31'h0, ab}, 32'h1);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_COUNT, `DDIO_RST_COUNT, 1'h0);
    $display("test reset_and_refusals done");
    for (int i = 0; i < 24; i++)
    begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0005 : ddio_gp_t'($urandom);
      @(posedge clk);
      gp_in <= v;
      repeat (2) @(posedge clk);
      rd_exp(`DDIO_IDX_INPUT_STATUS, `DDIO_SUB_VAR, exp_status(v), 1'h0);
    end
    $display("test inputs done");
    wr_out(`DDIO_SUB_LEVEL, 32'h00010000);
    wr_out(`DDIO_SUB_MASK, 32'h00030000);
    wr_out(`DDIO_SUB_MASK, 32'h000C0000);
    wr_out(`DDIO_SUB_LEVEL, 32'h0004FFFF);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_LEVEL, 32'h00040000, 1'h0);
    wr_out(`DDIO_SUB_MASK, 32'h0300FFFF);
    for (int i = 0; i < 40; i++)
      wr_out(($urandom % 2) ? `DDIO_SUB_LEVEL : `DDIO_SUB_MASK, $urandom);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_LEVEL, {lvl, 16'h0000}, 1'h0);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_MASK, {msk, 16'h0000}, 1'h0);
    $display("test outputs done");
    wr_out(`DDIO_SUB_LEVEL, 32'h00FF0000);
    wr_out(`DDIO_SUB_MASK, 32'h00FF0000);
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    lvl = 16'h0000;
    msk = 16'h0000;
    exp_out = 16'h0000;
    #1;
    chk("gp_out_rst", {16'h0, gp_out}, 32'h0);
    chk("emcy_outs_rst", {16'h0, emcy_outs}, 32'h0);
    rd_exp(`DDIO_IDX_INPUT_STATUS, `DDIO_SUB_VAR, exp_status(gp_in), 1'h0);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_LEVEL, `DDIO_RST_LEVEL, 1'h0);
    rd_exp(`DDIO_IDX_OUTPUTS, `DDIO_SUB_MASK, `DDIO_RST_MASK, 1'h0);
    $display("test midrun_reset done");
    stop_test();
  end
endmodule
